// [logic/bsfr_bank0.sv]
// bank 0 special-function register file with apb access and core port
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

module bsfr_bank0
  import bsfr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_on_reset,
  input  wire logic        warm_reset,
  input  wire logic [7:0]  data_addr,
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  conversion_value,
  output logic      [12:0] program_counter,
  output logic             bank1_select,
  output logic      [7:0]  port_a_dir_input,
  output logic      [7:0]  port_b_dir_input,
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_b_out
);

  logic [7:0]  regs      [0:31];
  logic [7:0]  next_regs [0:31];
  logic [12:0] next_program_counter;
  logic [7:0]  next_port_a_dir_input;
  logic [7:0]  next_port_b_dir_input;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_bank1_select;
  logic [4:0]  word;
  logic        setup;
  logic        wr_fire;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        mapped;

  assign word    = paddr[6:2];
  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign wbyte   = pwdata[7:0];

  // address decode; offsets above 1Fh or misaligned are unmapped
  always_comb begin
    mapped = 1'b1;
    if (paddr[31:7] != 25'h0000000 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (word >= 5'h07 && word <= 5'h09) begin
      mapped = 1'b0;
    end else if (word == 5'h0D || word == 5'h13 || word == 5'h14) begin
      mapped = 1'b0;
    end else if (word >= 5'h1A && word <= 5'h1D) begin
      mapped = 1'b0;
    end
  end

  // read mux; pins never reach the port addresses, only the latches do
  always_comb begin
    rbyte = 8'h00;
    if (!mapped) begin
      rbyte = 8'h00;
    end else if (word == OFS_INDIRECT_ACCESS_WINDOW) begin
      rbyte = 8'h00;
    end else if (word == OFS_PC_LOW_BYTE) begin
      rbyte = program_counter[7:0];
    end else if (word == OFS_CONVERSION_RESULT) begin
      rbyte = conversion_value;
    end else begin
      rbyte = regs[word];
    end
  end

  // next-state for the register array, one slice per offset
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      always_comb begin
        logic [7:0] msk;
        msk = 8'hFF;
        if (IDX == OFS_PC_HIGH_HOLDING) begin
          msk = MASK_PC_HIGH_HOLDING;
        end else if (IDX == OFS_PERIPHERAL_IRQ_FLAGS) begin
          msk = MASK_PERIPHERAL_IRQ;
        end else if (IDX == OFS_PORT_A_LATCH) begin
          msk = MASK_PORT_A;
        end else if (IDX == OFS_TIMER1_CONTROL) begin
          msk = MASK_TIMER1_CONTROL;
        end else if (IDX == OFS_TIMER2_CONTROL) begin
          msk = MASK_TIMER2_CONTROL;
        end else if (IDX == OFS_AUTO_SHUTDOWN_CONTROL) begin
          msk = MASK_AUTO_SHUTDOWN;
        end else if (IDX == OFS_CONVERTER_CONTROL) begin
          msk = MASK_CONVERTER_CTRL;
        end else if (IDX == OFS_CORE_STATUS) begin
          msk = MASK_STATUS_WRITABLE; // timeout/powerdown are read-only
        end
        next_regs[gi] = regs[gi];
        if (warm_reset) begin
          // clear-pin/watchdog reset keeps data regs except timer 2 count, pc holding latch and irq flags, restores control ones except interrupt control
          if (IDX == OFS_PC_HIGH_HOLDING || IDX == OFS_TIMER1_CONTROL ||
              IDX == OFS_TIMER2_CONTROL || IDX == OFS_CAPCMP_CONTROL ||
              IDX == OFS_PWM_DEADBAND_CONTROL || IDX == OFS_AUTO_SHUTDOWN_CONTROL ||
              IDX == OFS_CONVERTER_CONTROL || IDX == OFS_TIMER2_COUNT ||
              IDX == OFS_PERIPHERAL_IRQ_FLAGS) begin
            next_regs[gi] = RST_ZERO;
          end else if (IDX == OFS_CORE_STATUS) begin
            next_regs[gi] = {3'h0, regs[gi][4:0]};
          end
        end else if (wr_fire && mapped && word == IDX) begin
          next_regs[gi] = (regs[gi] & ~msk) | (wbyte & msk);
        end
      end
    end
  endgenerate

  // program counter, bank select and direction next values
  always_comb begin
    next_program_counter  = program_counter;
    next_port_a_dir_input = port_a_dir_input;
    next_port_b_dir_input = port_b_dir_input;
    if (warm_reset) begin
      next_program_counter  = 13'h0000;
      next_port_a_dir_input = RST_DIR_INPUT;
      next_port_b_dir_input = RST_DIR_INPUT;
    end else if (wr_fire && mapped && word == OFS_PC_LOW_BYTE) begin
      // whole address moves in one step so no half-updated jump target
      next_program_counter = {regs[OFS_PC_HIGH_HOLDING][4:0], wbyte};
    end
    next_bank1_select = next_regs[OFS_CORE_STATUS][STAT_BSL_BIT];
  end

  // apb answer: no wait state, data registered with pready
  always_comb begin
    next_pready = setup;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = {24'h000000, rbyte};
    end else if (pready) begin
      next_prdata = 32'h00000000;
    end
  end

  // registers; async reset is presetn only, clear-pin resets take the synchronous warm_reset path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= RST_ZERO;
      end
      regs[OFS_CORE_STATUS] <= RST_CORE_STATUS;
      program_counter       <= 13'h0000;
      port_a_dir_input      <= RST_DIR_INPUT;
      port_b_dir_input      <= RST_DIR_INPUT;
      bank1_select          <= 1'b0;
      prdata                <= 32'h00000000;
      pready                <= 1'b0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= next_regs[i];
      end
      program_counter  <= next_program_counter;
      port_a_dir_input <= next_port_a_dir_input;
      port_b_dir_input <= next_port_b_dir_input;
      bank1_select     <= next_bank1_select;
      prdata           <= next_prdata;
      pready           <= next_pready;
    end
  end

  assign pslverr    = 1'b0;
  assign port_a_out = regs[OFS_PORT_A_LATCH];
  assign port_b_out = regs[OFS_PORT_B_LATCH];

  // shared core registers are bank-independent: data_addr bit 7 never
  // enters the decode above, so both banks see the same file

  // assertions
  a_pc_load_full: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && mapped && word == OFS_PC_LOW_BYTE && !warm_reset) |=>
      program_counter == {$past(regs[OFS_PC_HIGH_HOLDING][4:0]), $past(wbyte)})
    else $error("pc not loaded from holding latch and low byte");
  a_holding_width: assert property (@(posedge pclk) disable iff (!presetn)
    regs[OFS_PC_HIGH_HOLDING][7:5] == 3'h0)
    else $error("holding latch upper bits set");
  a_pc_stable: assert property (@(posedge pclk) disable iff (!presetn)
    (!warm_reset && !(wr_fire && word == OFS_PC_LOW_BYTE)) |=> $stable(program_counter))
    else $error("pc changed without low byte write");
  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && !mapped) |=> (pready && prdata == 32'h00000000))
    else $error("unmapped read not zero");
  a_shutdown_bit5: assert property (@(posedge pclk) disable iff (!presetn)
    regs[OFS_AUTO_SHUTDOWN_CONTROL][5] == 1'b0)
    else $error("auto-shutdown bit 5 set");
  a_warm_dir_input: assert property (@(posedge pclk) disable iff (!presetn)
    warm_reset |=> (port_a_dir_input == RST_DIR_INPUT && port_b_dir_input == RST_DIR_INPUT))
    else $error("ports not inputs after reset");
  a_warm_keeps_port: assert property (@(posedge pclk) disable iff (!presetn)
    warm_reset |=> (port_b_out == $past(port_b_out) && program_counter == 13'h0000))
    else $error("warm reset values wrong");
  a_bank_follow: assert property (@(posedge pclk) disable iff (!presetn)
    bank1_select == regs[OFS_CORE_STATUS][STAT_BSL_BIT])
    else $error("bank select not following status");
  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("pready not single cycle");

endmodule

// [logic/bsfr_pkg.sv]
// constants for the bank 0 special-function register block
package bsfr_pkg;
  // word offsets (file address times four on the apb side)
  localparam logic [4:0] OFS_INDIRECT_ACCESS_WINDOW = 5'h00;
  localparam logic [4:0] OFS_TIMER0_COUNT           = 5'h01;
  localparam logic [4:0] OFS_PC_LOW_BYTE            = 5'h02;
  localparam logic [4:0] OFS_CORE_STATUS            = 5'h03;
  localparam logic [4:0] OFS_INDIRECT_POINTER       = 5'h04;
  localparam logic [4:0] OFS_PORT_A_LATCH           = 5'h05;
  localparam logic [4:0] OFS_PORT_B_LATCH           = 5'h06;
  localparam logic [4:0] OFS_PC_HIGH_HOLDING        = 5'h0A;
  localparam logic [4:0] OFS_INTERRUPT_CONTROL      = 5'h0B;
  localparam logic [4:0] OFS_PERIPHERAL_IRQ_FLAGS   = 5'h0C;
  localparam logic [4:0] OFS_TIMER1_COUNT_LOW       = 5'h0E;
  localparam logic [4:0] OFS_TIMER1_COUNT_HIGH      = 5'h0F;
  localparam logic [4:0] OFS_TIMER1_CONTROL         = 5'h10;
  localparam logic [4:0] OFS_TIMER2_COUNT           = 5'h11;
  localparam logic [4:0] OFS_TIMER2_CONTROL         = 5'h12;
  localparam logic [4:0] OFS_CAPCMP_VALUE_LOW       = 5'h15;
  localparam logic [4:0] OFS_CAPCMP_VALUE_HIGH      = 5'h16;
  localparam logic [4:0] OFS_CAPCMP_CONTROL         = 5'h17;
  localparam logic [4:0] OFS_PWM_DEADBAND_CONTROL   = 5'h18;
  localparam logic [4:0] OFS_AUTO_SHUTDOWN_CONTROL  = 5'h19;
  localparam logic [4:0] OFS_CONVERSION_RESULT      = 5'h1E;
  localparam logic [4:0] OFS_CONVERTER_CONTROL      = 5'h1F;
  // writable-bit masks; clear bits keep their reset value, zero except status TO/PD
  localparam logic [7:0] MASK_PC_HIGH_HOLDING  = 8'h1F;
  localparam logic [7:0] MASK_PERIPHERAL_IRQ   = 8'h47;
  localparam logic [7:0] MASK_PORT_A           = 8'h1F;
  localparam logic [7:0] MASK_TIMER1_CONTROL   = 8'h3F;
  localparam logic [7:0] MASK_TIMER2_CONTROL   = 8'h7F;
  localparam logic [7:0] MASK_AUTO_SHUTDOWN    = 8'hDF;
  localparam logic [7:0] MASK_CONVERTER_CTRL   = 8'hFD;
  localparam logic [7:0] MASK_STATUS_WRITABLE  = 8'hE7;
  // status field positions
  localparam int STAT_IRP_BIT = 7;
  localparam int STAT_BSH_BIT = 6;
  localparam int STAT_BSL_BIT = 5;
  localparam int STAT_TO_BIT  = 4;
  localparam int STAT_PD_BIT  = 3;
  // reset values
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_CORE_STATUS = 8'h18;
  localparam logic [7:0] RST_DIR_INPUT   = 8'hFF;
  // bank-1 address split
  localparam logic [7:0] BANK1_BASE = 8'h80;
endpackage

// [tb/bsfr_core_model.sv]
// behavioural model of the core datapath side of the bank 0 registers
`timescale 1ns/1ps
module bsfr_core_model (
  input  wire logic       pclk,
  input  wire logic       hi_bank,
  input  wire logic       warm_req,
  input  wire logic [7:0] adc_val,
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_b_out,
  output logic      [7:0] data_addr,
  output logic            warm_reset,
  output logic      [7:0] port_a_pins,
  output logic      [7:0] port_b_pins,
  output logic      [7:0] conversion_value
);
  // core address follows the selected bank; shared status lives at 03h and 83h
  always_ff @(posedge pclk) begin
    data_addr        <= hi_bank ? 8'h83 : 8'h03;
    warm_reset       <= warm_req; // clear-pin or watchdog reset, one cycle late
    conversion_value <= adc_val;
    // loaded pins sit opposite the latches, so a read of the pins would show
    port_a_pins      <= ~port_a_out;
    port_b_pins      <= ~port_b_out;
  end
endmodule

// [tb/test_bank0_sfr_map.sv]
// self-checking testbench for the bank 0 register block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_bank0_sfr_map
  import bsfr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        hi_bank, warm_req, warm_reset, bank1_select;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  data_addr, pa_pins, pb_pins, conv, adc, pa_dir, pb_dir, pa_out, pb_out;
  logic [12:0] pc;
  int          err_count, total_checks;
  // registers cleared by warm reset and their writable masks, then the holes in the map
  logic [4:0]  co [9] = '{5'h0A, 5'h0C, 5'h10, 5'h11, 5'h12, 5'h17, 5'h18, 5'h19, 5'h1F};
  logic [7:0]  cm [9] = '{8'h1F, 8'h47, 8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hDF, 8'hFD};
  logic [4:0]  um [10] = '{5'h07, 5'h08, 5'h09, 5'h0D, 5'h13, 5'h14, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  bsfr_bank0 uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_on_reset(1'b0), .warm_reset(warm_reset),
    .data_addr(data_addr), .port_a_pins(pa_pins), .port_b_pins(pb_pins),
    .conversion_value(conv), .program_counter(pc), .bank1_select(bank1_select),
    .port_a_dir_input(pa_dir), .port_b_dir_input(pb_dir), .port_a_out(pa_out),
    .port_b_out(pb_out));

  bsfr_core_model core (.pclk(pclk), .hi_bank(hi_bank), .warm_req(warm_req), .adc_val(adc),
    .port_a_out(pa_out), .port_b_out(pb_out), .data_addr(data_addr), .warm_reset(warm_reset),
    .port_a_pins(pa_pins), .port_b_pins(pb_pins), .conversion_value(conv));

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; pready and prdata are taken at the rising edge that ends it
  task automatic xfer(input logic [4:0] ofs, input logic wr, input logic [7:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {25'h0, ofs, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    if (n >= 64) err_count++;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] ofs, input logic [7:0] d);
    logic [31:0] r;
    xfer(ofs, 1'b1, d, r);
  endtask

  task automatic rc(input logic [4:0] ofs, input logic [7:0] ex);
    logic [31:0] r;
    xfer(ofs, 1'b0, 8'h00, r);
    `CHK($sformatf("reg %h", ofs), {24'h0, ex}, r)
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    hi_bank = 1'b0; warm_req = 1'b0; adc = 8'h00; err_count = 0; total_checks = 0;
    repeat (20) @(posedge pclk);
    `CHK("dir a", 8'hFF, pa_dir)
    `CHK("dir b", 8'hFF, pb_dir)
    presetn <= 1'b1;
    rc(OFS_CORE_STATUS, 8'h18);
    rc(OFS_PC_LOW_BYTE, 8'h00);
    for (int i = 0; i < 9; i++) rc(co[i], 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(co[i], 8'hFF);
      rc(co[i], cm[i]);
    end
    for (int j = 0; j < 10; j++) begin
      wr(um[j], 8'hFF);
      rc(um[j], 8'h00);
    end
    wr(OFS_PC_LOW_BYTE, 8'h34);
    @(negedge pclk);
    `CHK("pc", 13'h1F34, pc)
    rc(OFS_PC_LOW_BYTE, 8'h34);
    wr(OFS_PORT_B_LATCH, 8'h5A);
    rc(OFS_PORT_B_LATCH, 8'h5A);
    `CHK("port b out", 8'h5A, pb_out)
    wr(OFS_PORT_A_LATCH, 8'hFF);
    rc(OFS_PORT_A_LATCH, 8'h1F);
    // only the bank-select bit is written; the read-only TO and PD bits stay set
    wr(OFS_CORE_STATUS, 8'h20);
    @(negedge pclk);
    `CHK("bank1", 1'b1, bank1_select)
    rc(OFS_CORE_STATUS, 8'h38);
    hi_bank <= 1'b1;
    rc(OFS_CORE_STATUS, 8'h38);
    rc(OFS_PC_HIGH_HOLDING, 8'h1F);
    adc <= 8'hA5;
    wr(OFS_CONVERSION_RESULT, 8'h00);
    rc(OFS_CONVERSION_RESULT, 8'hA5);
    @(posedge pclk);
    warm_req <= 1'b1;
    @(posedge pclk);
    warm_req <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK("pc warm", 13'h0000, pc)
    `CHK("dir b warm", 8'hFF, pb_dir)
    `CHK("bank1 warm", 1'b0, bank1_select)
    rc(OFS_CORE_STATUS, 8'h18);
    for (int i = 0; i < 9; i++) rc(co[i], 8'h00);
    rc(OFS_PORT_B_LATCH, 8'h5A);
    print_verdict();
  end
endmodule
